// ---- sim/aig_led_drv_model.sv ----
// Purpose: model of the external LED driver taking per-colour current commands
// Assumes: commands are valid in the cycle that the update pulse is high
// Notes:   holds the last latched currents; zero out of reset

module aig_led_drv_model (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       update_in,
  input  wire logic [9:0] cmd_red_in,
  input  wire logic [9:0] cmd_green_in,
  input  wire logic [9:0] cmd_blue_in,
  output logic      [9:0] drive_red_out,
  output logic      [9:0] drive_green_out,
  output logic      [9:0] drive_blue_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // one current per colour
  // commands between pulses are ignored, as a real driver latches them
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      drive_red_out   <= 10'h000;
      drive_green_out <= 10'h000;
      drive_blue_out  <= 10'h000;
    end else if (update_in) begin
      drive_red_out   <= cmd_red_in;
      drive_green_out <= cmd_green_in;
      drive_blue_out  <= cmd_blue_in;
    end
  end

endmodule : aig_led_drv_model

// ---- sim/tb.sv ----
// Purpose: self-checking bench for the adaptive illumination gain block
// Assumes: frames of 20 pixels, 20 cycles blanking after each frame end except one 2-cycle gap
// Notes:   expected gains and currents are worked out here from the rules

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------
  // stimulus and observed signals
  // ----------
  logic        clk   = 1'b0;
  logic        rst_n = 1'b0;
  logic        fs    = 1'b0;
  logic        fe    = 1'b0;
  logic        pv    = 1'b0;
  logic        en    = 1'b0;
  logic [7:0]  pr    = 8'h00;
  logic [7:0]  pg    = 8'h00;
  logic [7:0]  pb    = 8'h00;
  logic [7:0]  set   = 8'h00;
  logic [19:0] clip  = 20'h0_0004;
  logic [9:0]  nom [3] = '{10'h200, 10'h258, 10'h190};
  logic        vo, upd;
  logic [7:0]  ro, go, bo;
  logic [12:0] gr, gg, gb;
  logic [9:0]  lr, lg, lb, dr, dg, db;
  int          error_cnt = 0;
  int          checked   = 0;
  int          eg [3];
  int          el [3];

  initial begin
    forever #20 clk = ~clk;
  end

  aig_core #(.CNT_W(20), .LED_W(10)) u_aig_core (
    .clk_in(clk), .rst_n_in(rst_n), .frame_start_in(fs), .frame_end_in(fe),
    .pix_valid_in(pv), .pix_red_in(pr), .pix_green_in(pg), .pix_blue_in(pb),
    .content_adaptive_illumination_en_in(en), .gain_setting_in(set),
    .clip_limit_in(clip), .led_nominal_red_in(nom[0]),
    .led_nominal_green_in(nom[1]), .led_nominal_blue_in(nom[2]),
    .pix_valid_out(vo), .pix_red_out(ro), .pix_green_out(go), .pix_blue_out(bo),
    .gain_red_out(gr), .gain_green_out(gg), .gain_blue_out(gb),
    .led_cmd_red_out(lr), .led_cmd_green_out(lg), .led_cmd_blue_out(lb),
    .led_update_out(upd)
  );

  aig_led_drv_model u_aig_led_drv_model (
    .clk_in(clk), .rst_n_in(rst_n), .update_in(upd),
    .cmd_red_in(lr), .cmd_green_in(lg), .cmd_blue_in(lb),
    .drive_red_out(dr), .drive_green_out(dg), .drive_blue_out(db)
  );

  // ----------
  // helpers
  // ----------
  task automatic finish_test();
    if (error_cnt == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  function automatic int sat(input int p, input int g);
    int v;
    v = (p * g) >> 8;
    return (v > 255) ? 255 : v;
  endfunction : sat

  // knee bins in, gains and clamped currents out
  function automatic void calc(input int b0, input int b1, input int b2, input int s);
    int b [3];
    int gmin;
    int bst;
    int v;
    b = '{b0, b1, b2};
    for (int i = 0; i < 3; i++) begin
      eg[i] = 4096 / (b[i] + 1);
    end
    gmin = (eg[0] < eg[1]) ? eg[0] : eg[1];
    gmin = (eg[2] < gmin) ? eg[2] : gmin;
    bst = 256 + ((s * (gmin - 256)) >> 8);
    for (int i = 0; i < 3; i++) begin
      v = (int'(nom[i]) * bst * (b[i] + 1)) >> 12;
      el[i] = (v > int'(nom[i])) ? int'(nom[i]) : v;
    end
  endfunction : calc

  function automatic void unity();
    for (int i = 0; i < 3; i++) begin
      eg[i] = 256;
      el[i] = int'(nom[i]);
    end
  endfunction : unity

  task automatic chk_state();
    cmp(16'(gr), 16'(eg[0]));
    cmp(16'(gg), 16'(eg[1]));
    cmp(16'(gb), 16'(eg[2]));
    cmp(16'(lr), 16'(el[0]));
    cmp(16'(lg), 16'(el[1]));
    cmp(16'(lb), 16'(el[2]));
  endtask : chk_state

  // ----------
  // scenario tasks
  // ----------
  task automatic start_frame(input logic upd_exp);
    fs = 1'b1;
    @(negedge clk);
    fs = 1'b0;
    cmp(16'(upd), 16'(upd_exp));
    chk_state();
    @(negedge clk);
    cmp(16'(upd), 16'h0000);
    cmp(16'(dr), 16'(el[0]));
    cmp(16'(dg), 16'(el[1]));
    cmp(16'(db), 16'(el[2]));
  endtask : start_frame

  // back-to-back pixels, each output checked one cycle after its input
  task automatic pixels(input logic [7:0] r, input logic [7:0] g, input logic [7:0] b,
                        input int nhi);
    logic [7:0] cr;
    cr = r;
    for (int i = 0; i <= 20; i++) begin
      if (i > 0) begin
        cmp(16'(vo), 16'h0001);
        cmp(16'(ro), 16'(sat(int'(cr), eg[0])));
        cmp(16'(go), 16'(sat(int'(g), eg[1])));
        cmp(16'(bo), 16'(sat(int'(b), eg[2])));
      end
      cr = (i < nhi) ? 8'hFA : r;
      pv = (i < 20);
      pr = cr;
      pg = g;
      pb = b;
      @(negedge clk);
    end
    cmp(16'(vo), 16'h0000);
  endtask : pixels

  task automatic end_frame(input int gap);
    fe = 1'b1;
    @(negedge clk);
    fe = 1'b0;
    repeat (gap) @(negedge clk);
    chk_state();
  endtask : end_frame

  // ----------
  // main sequence
  // ----------
  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    eg = '{256, 256, 256};
    el = '{0, 0, 0};
    chk_state();
    cmp(16'(vo), 16'h0000);
    unity();
    start_frame(1'b1);
    pixels(8'h64, 8'hFF, 8'h10, 0);
    en = 1'b1;
    start_frame(1'b0);
    pixels(8'h64, 8'h7F, 8'h32, 4);
    end_frame(20);
    calc(6, 7, 3, 0);
    start_frame(1'b1);
    pixels(8'h64, 8'h7F, 8'h32, 4);
    set = 8'hFF;
    end_frame(20);
    calc(6, 7, 3, 255);
    start_frame(1'b1);
    pixels(8'h64, 8'h7F, 8'h32, 4);
    clip = 20'h0_0003;
    end_frame(20);
    calc(15, 7, 3, 255);
    start_frame(1'b1);
    // black red and green, white blue, in power saving
    pixels(8'h00, 8'h00, 8'hFF, 0);
    set = 8'h00;
    end_frame(20);
    calc(0, 0, 15, 0);
    start_frame(1'b1);
    pixels(8'h64, 8'h7F, 8'h32, 4);
    // boundary during the scan drops that frame's result
    end_frame(2);
    start_frame(1'b0);
    en = 1'b0;
    unity();
    start_frame(1'b1);
    finish_test();
  end

  // whole run is under 800 cycles
  initial begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    finish_test();
  end

endmodule : tb

// ---- src/aig_chan_hist.sv ----
// Purpose: per-channel frame histogram and clip-knee search
// Assumes: frame_start_in precedes the first pixel of a frame
// Notes:   scan runs from the top bin down, one bin per cycle

module aig_chan_hist #(
  parameter int CNT_W = aig_pkg::CNT_W
) (
  input  wire logic                         clk_in,
  input  wire logic                         rst_n_in,
  input  wire logic                         frame_start_in,
  input  wire logic                         pix_valid_in,
  input  wire logic [aig_pkg::PIX_W-1:0]    pix_in,
  input  wire logic                         scan_start_in,
  input  wire logic [CNT_W-1:0]             clip_limit_in,
  output logic      [aig_pkg::BIN_BITS-1:0] knee_bin_out,
  output logic                              done_out
);

  generate
    if (CNT_W < 8 || CNT_W > 28) begin : g_bad_cnt
      $error("aig_chan_hist: CNT_W out of range");
    end
  endgenerate

  typedef struct packed {
    logic [aig_pkg::NUM_BINS-1:0][CNT_W-1:0] hist;
    logic [CNT_W+3:0]                        acc;
    logic [aig_pkg::BIN_BITS-1:0]            bin;
    logic                                    scan;
    logic [aig_pkg::BIN_BITS-1:0]            knee;
    logic                                    done;
  } aig_hist_state_type;

  aig_hist_state_type r, r_nxt;
  logic [aig_pkg::BIN_BITS-1:0] pix_bin;
  logic [CNT_W+3:0]             sum;

  assign pix_bin = pix_in[aig_pkg::PIX_W-1 -: aig_pkg::BIN_BITS];
  assign sum     = r.acc + {4'h0, r.hist[r.bin]};

  always_comb begin
    r_nxt      = r;
    r_nxt.done = 1'b0;
    if (frame_start_in) begin
      r_nxt.hist = '0;
      r_nxt.acc  = '0;
      r_nxt.scan = 1'b0;
    end else begin
      if (pix_valid_in && r.hist[pix_bin] != {CNT_W{1'b1}}) begin
        r_nxt.hist[pix_bin] = r.hist[pix_bin] + CNT_W'(1);
      end
      if (scan_start_in && !r.scan) begin
        r_nxt.scan = 1'b1;
        r_nxt.bin  = aig_pkg::BIN_TOP;
        r_nxt.acc  = '0;
      end else if (r.scan) begin
        // stop where clipped pixels would exceed the limit
        if (sum > {4'h0, clip_limit_in} || r.bin == '0) begin
          r_nxt.knee = r.bin;
          r_nxt.done = 1'b1;
          r_nxt.scan = 1'b0;
        end else begin
          r_nxt.acc = sum;
          r_nxt.bin = r.bin - aig_pkg::BIN_BITS'(1);
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r <= '0;
    end else begin
      r <= r_nxt;
    end
  end

  assign knee_bin_out = r.knee;
  assign done_out     = r.done;

  chk_clip_bound: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    done_out |-> r.acc <= {4'h0, clip_limit_in})
    else $error("pixels above the knee exceed the clip limit");

  chk_scan_bound: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (scan_start_in && !r.scan && !frame_start_in) |-> ##[1:17] (done_out || frame_start_in))
    else $error("knee search did not finish in time");

endmodule : aig_chan_hist

// ---- src/aig_core.sv ----
// Purpose: content_adaptive_illumination gain and LED current control
// Assumes: pixel stream and settings on clk_in; one frame_end_in per frame
// Notes:   new gains and currents are loaded only on frame_start_in

// Overview of operation
// - derive one gain per colour each frame
// - multiply each channel's pixels by its gain
// - gain clips only a few pixels
// - separate LED current command per colour
// - pick gain and LED power together
// - hold white point at target balance
// - power mode: lower LED, raise gain
// - brightness mode: LED near nominal, gain boosts
// - setting blends power and brightness modes
// - dimmer content gives lower LED power
module aig_core #(
  parameter int CNT_W = aig_pkg::CNT_W,
  parameter int LED_W = aig_pkg::LED_W
) (
  input  wire logic                       clk_in,
  input  wire logic                       rst_n_in,
  input  wire logic                       frame_start_in,
  input  wire logic                       frame_end_in,
  input  wire logic                       pix_valid_in,
  input  wire logic [aig_pkg::PIX_W-1:0]  pix_red_in,
  input  wire logic [aig_pkg::PIX_W-1:0]  pix_green_in,
  input  wire logic [aig_pkg::PIX_W-1:0]  pix_blue_in,
  input  wire logic                       content_adaptive_illumination_en_in,
  input  wire logic [aig_pkg::SET_W-1:0]  gain_setting_in,
  input  wire logic [CNT_W-1:0]           clip_limit_in,
  input  wire logic [LED_W-1:0]           led_nominal_red_in,
  input  wire logic [LED_W-1:0]           led_nominal_green_in,
  input  wire logic [LED_W-1:0]           led_nominal_blue_in,
  output logic                            pix_valid_out,
  output logic      [aig_pkg::PIX_W-1:0]  pix_red_out,
  output logic      [aig_pkg::PIX_W-1:0]  pix_green_out,
  output logic      [aig_pkg::PIX_W-1:0]  pix_blue_out,
  output logic      [aig_pkg::GAIN_W-1:0] gain_red_out,
  output logic      [aig_pkg::GAIN_W-1:0] gain_green_out,
  output logic      [aig_pkg::GAIN_W-1:0] gain_blue_out,
  output logic      [LED_W-1:0]           led_cmd_red_out,
  output logic      [LED_W-1:0]           led_cmd_green_out,
  output logic      [LED_W-1:0]           led_cmd_blue_out,
  output logic                            led_update_out
);

  // ----------------------------------------------------------------
  // parameter checks and local widths
  // ----------------------------------------------------------------
  generate
    if (LED_W < 4 || LED_W > 16) begin : g_bad_led
      $error("aig_core: LED_W out of range");
    end
  endgenerate

  localparam int NCH = aig_pkg::NUM_CH;
  localparam int GW  = aig_pkg::GAIN_W;
  localparam int PXW = aig_pkg::PIX_W;
  localparam int BB  = aig_pkg::BIN_BITS;
  localparam int PW  = LED_W + GW + BB + 1;
  localparam int XW  = PXW + GW;

  typedef struct packed {
    aig_pkg::aig_phase_type          phase;
    logic [NCH-1:0]                  got;
    logic [NCH-1:0][BB-1:0]          knee;
    logic [GW-1:0]                   boost;
    logic [NCH-1:0][GW-1:0]          gain_calc;
    logic [NCH-1:0][LED_W-1:0]       led_calc;
    logic [NCH-1:0][GW-1:0]          gain;
    logic [NCH-1:0][LED_W-1:0]       led;
    logic                            led_upd;
    logic                            pv;
    logic [NCH-1:0][PXW-1:0]         pix;
  } aig_core_state_type;

  aig_core_state_type r, r_nxt;

  logic [NCH-1:0][PXW-1:0]   pix_a;
  logic [NCH-1:0][LED_W-1:0] nom_a;
  logic [NCH-1:0][BB-1:0]    knee_a;
  logic [NCH-1:0]            done_a;

  assign pix_a = {pix_blue_in, pix_green_in, pix_red_in};
  assign nom_a = {led_nominal_blue_in, led_nominal_green_in, led_nominal_red_in};

  // ----------------------------------------------------------------
  // per-channel statistics
  // ----------------------------------------------------------------
  for (genvar c = 0; c < NCH; c++) begin : g_hist
    aig_chan_hist #(
      .CNT_W (CNT_W)
    ) u_hist (
      .clk_in         (clk_in),
      .rst_n_in       (rst_n_in),
      .frame_start_in (frame_start_in),
      .pix_valid_in   (pix_valid_in),
      .pix_in         (pix_a[c]),
      .scan_start_in  (frame_end_in),
      .clip_limit_in  (clip_limit_in),
      .knee_bin_out   (knee_a[c]),
      .done_out       (done_a[c])
    );
  end

  // ----------------------------------------------------------------
  // gain and LED power selection
  // ----------------------------------------------------------------
  logic [BB-1:0]             kmax;
  logic [GW-1:0]             gmin;
  logic [GW-1:0]             boost_v;
  logic [19:0]               blend;
  logic [NCH-1:0][GW-1:0]    gain_v;
  logic [NCH-1:0][LED_W-1:0] led_v;
  logic [NCH-1:0][PW-1:0]    pwr;
  logic [NCH-1:0][XW-1:0]    prod;
  logic [NCH-1:0][PXW-1:0]   pix_v;

  always_comb begin
    kmax = r.knee[0];
    for (int c = 1; c < NCH; c++) begin
      if (r.knee[c] > kmax) begin
        kmax = r.knee[c];
      end
    end
    // one common brightness factor keeps the white point
    gmin = aig_pkg::gain_of_bin(kmax);
    // setting 0 is pure power saving, full scale pure boost
    blend   = 20'(gain_setting_in) * 20'(gmin - aig_pkg::GAIN_UNITY);
    // top setting lifts all channels by about Gmin
    boost_v = aig_pkg::GAIN_UNITY + GW'(blend >> aig_pkg::SET_SHIFT);
    for (int c = 0; c < NCH; c++) begin
      // gain and power chosen as one pair
      gain_v[c] = aig_pkg::gain_of_bin(r.knee[c]);
      // led = nominal * boost / gain, so brightness tracks boost
      pwr[c] = PW'(nom_a[c]) * PW'(boost_v) * PW'({1'b0, r.knee[c]} + 5'h01);
      pwr[c] = pwr[c] >> aig_pkg::LED_SHIFT;
      // dim content lowers power, never above nominal
      led_v[c] = (pwr[c] > PW'(nom_a[c])) ? nom_a[c] : pwr[c][LED_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // pixel gain path
  // ----------------------------------------------------------------
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      // scale and saturate at full scale
      prod[c]  = XW'(pix_a[c]) * XW'(r.gain[c]);
      pix_v[c] = (|prod[c][XW-1:PXW+aig_pkg::GAIN_FRAC]) ? aig_pkg::PIX_MAX
               : prod[c][PXW+aig_pkg::GAIN_FRAC-1:aig_pkg::GAIN_FRAC];
    end
  end

  // ----------------------------------------------------------------
  // frame sequencing
  // ----------------------------------------------------------------
  always_comb begin
    r_nxt         = r;
    r_nxt.led_upd = 1'b0;
    r_nxt.pv      = pix_valid_in;
    r_nxt.pix     = pix_v;
    unique case (r.phase)
      aig_pkg::PH_IDLE: begin
        if (frame_end_in && !frame_start_in) begin
          r_nxt.phase = aig_pkg::PH_SCAN;
          r_nxt.got   = '0;
        end
      end
      aig_pkg::PH_SCAN: begin
        for (int c = 0; c < NCH; c++) begin
          if (done_a[c]) begin
            r_nxt.knee[c] = knee_a[c];
          end
        end
        r_nxt.got = r.got | done_a;
        if (frame_start_in) begin
          r_nxt.phase = aig_pkg::PH_IDLE;
        end else if (&(r.got | done_a)) begin
          r_nxt.phase = aig_pkg::PH_CALC;
        end
      end
      aig_pkg::PH_CALC: begin
        r_nxt.boost     = boost_v;
        r_nxt.gain_calc = gain_v;
        r_nxt.led_calc  = led_v;
        r_nxt.phase     = frame_start_in ? aig_pkg::PH_IDLE : aig_pkg::PH_PEND;
      end
      aig_pkg::PH_PEND: begin
        if (frame_start_in) begin
          r_nxt.phase = aig_pkg::PH_IDLE;
        end
      end
    endcase
    // gain and current outputs move only on a frame boundary
    if (frame_start_in) begin
      if (!content_adaptive_illumination_en_in) begin
        r_nxt.gain    = {NCH{aig_pkg::GAIN_UNITY}};
        r_nxt.led     = nom_a;
        r_nxt.led_upd = 1'b1;
      end else if (r.phase == aig_pkg::PH_PEND) begin
        // per-colour currents issued with their gains
        r_nxt.gain    = r.gain_calc;
        r_nxt.led     = r.led_calc;
        r_nxt.led_upd = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r       <= '0;
      r.gain  <= {NCH{aig_pkg::GAIN_UNITY}};
      r.boost <= aig_pkg::GAIN_UNITY;
    end else begin
      r <= r_nxt;
    end
  end

  assign pix_valid_out     = r.pv;
  assign pix_red_out       = r.pix[0];
  assign pix_green_out     = r.pix[1];
  assign pix_blue_out      = r.pix[2];
  assign gain_red_out      = r.gain[0];
  assign gain_green_out    = r.gain[1];
  assign gain_blue_out     = r.gain[2];
  assign led_cmd_red_out   = r.led[0];
  assign led_cmd_green_out = r.led[1];
  assign led_cmd_blue_out  = r.led[2];
  assign led_update_out    = r.led_upd;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence s_apply;
    frame_start_in && content_adaptive_illumination_en_in && r.phase == aig_pkg::PH_PEND;
  endsequence

  chk_bypass_unity: assert property (
    (frame_start_in && !content_adaptive_illumination_en_in) |=>
      r.gain == {NCH{aig_pkg::GAIN_UNITY}} && r.led == $past(nom_a) && led_update_out)
    else $error("disabled frame did not load unity gain and nominal current");

  chk_frame_only: assert property (
    ($changed(r.gain) || $changed(r.led)) |-> $past(frame_start_in))
    else $error("gain or current changed away from a frame start");

  chk_pixel_gain: assert property (
    pix_valid_in |=> pix_valid_out && pix_red_out == $past(pix_v[0])
      && (pix_red_out == aig_pkg::PIX_MAX || pix_red_out >= $past(pix_red_in)))
    else $error("red pixel not gained as expected");

  chk_apply_pair: assert property (
    s_apply |=> r.gain == $past(r.gain_calc) && r.led == $past(r.led_calc) && led_update_out)
    else $error("gain and current not loaded together");

  chk_gain_knee: assert property (
    (r.phase == aig_pkg::PH_CALC) |=>
      r.gain_calc[1] == aig_pkg::gain_of_bin(r.knee[1]))
    else $error("green gain does not match its knee");

  chk_power_mode: assert property (
    (r.phase == aig_pkg::PH_CALC && gain_setting_in == '0) |=>
      r.boost == aig_pkg::GAIN_UNITY
      && PW'(r.led_calc[0]) == ((PW'(nom_a[0]) * PW'({1'b0, r.knee[0]} + 5'h01)) >> 4))
    else $error("power saving current wrong for red");

  chk_white_nominal: assert property (
    (r.phase == aig_pkg::PH_CALC && r.knee[2] == aig_pkg::BIN_TOP) |=>
      r.led_calc[2] == $past(nom_a[2]))
    else $error("full white blue channel not at nominal current");

  chk_boost_range: assert property (
    (r.phase == aig_pkg::PH_CALC) |=>
      r.boost >= aig_pkg::GAIN_UNITY && r.boost <= $past(gmin))
    else $error("common brightness factor outside its range");

  chk_no_overdrive: assert property (
    led_update_out |-> r.led[0] <= nom_a[0] && r.led[1] <= nom_a[1] && r.led[2] <= nom_a[2])
    else $error("LED command above nominal");

  chk_stats_ready: assert property (
    (r.phase == aig_pkg::PH_SCAN && !frame_start_in) |-> ##[1:18]
      (r.phase == aig_pkg::PH_CALC || frame_start_in))
    else $error("statistics did not complete after frame end");

  // boundary that arrives before a result is ready
  sequence s_drop;
    frame_start_in && content_adaptive_illumination_en_in && r.phase != aig_pkg::PH_PEND;
  endsequence

  chk_drop_silent: assert property (
    s_drop |=> !led_update_out && $stable(r.gain) && $stable(r.led))
    else $error("frame boundary without a pending set changed the outputs");

  chk_update_cause: assert property (
    led_update_out |-> $past(frame_start_in))
    else $error("LED update pulse without a frame start");

endmodule : aig_core

// ---- src/aig_pkg.sv ----
// Purpose: shared constants and types for the adaptive illumination gain block
// Assumes: 8-bit colour channels, 16-bin coarse histogram per channel
// Notes:   gains are unsigned fixed point with 8 fraction bits

package aig_pkg;

  // ----------------------------------------------------------------
  // widths and counts
  // ----------------------------------------------------------------
  localparam int PIX_W     = 8;
  localparam int BIN_BITS  = 4;
  localparam int NUM_BINS  = 16;
  localparam int NUM_CH    = 3;
  localparam int GAIN_W    = 13;
  localparam int GAIN_FRAC = 8;
  localparam int SET_W     = 8;
  localparam int LED_W     = 10;
  localparam int CNT_W     = 20;
  // power = nominal * boost * (knee + 1) >> LED_SHIFT
  localparam int LED_SHIFT = 12;
  localparam int SET_SHIFT = 8;

  // ----------------------------------------------------------------
  // reset values and fixed points
  // ----------------------------------------------------------------
  localparam logic [GAIN_W-1:0]   GAIN_UNITY = 13'h0100;
  // full scale over one bin width, in gain units
  localparam logic [GAIN_W-1:0]   GAIN_FULL  = 13'h1000;
  localparam logic [BIN_BITS-1:0] BIN_TOP    = 4'hF;
  localparam logic [PIX_W-1:0]    PIX_MAX    = 8'hFF;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_SCAN = 2'b01,
    PH_CALC = 2'b11,
    PH_PEND = 2'b10
  } aig_phase_type;

  // gain that lifts the top of a bin to full scale
  function automatic logic [GAIN_W-1:0] gain_of_bin(input logic [BIN_BITS-1:0] bin);
    logic [GAIN_W-1:0] g;
    g = GAIN_UNITY;
    for (int i = 0; i < NUM_BINS; i++) begin
      if (bin == BIN_BITS'(i)) begin
        g = GAIN_W'(32'(GAIN_FULL) / (i + 1));
      end
    end
    return g;
  endfunction : gain_of_bin

endpackage : aig_pkg
